// ===== rtl/aic_top.sv
// Channel configuration, scan sequencing and sample delivery for analog inputs.
`timescale 1ns/10ps
module aic_top #(
  parameter int TICK_CYCLES = aic_pkg::TICK_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic diff_mode_in,
  input wire logic buffered_variable_count_mode_in,
  input wire logic gain_wr_in,
  input wire logic [3:0] gain_chan_in,
  input wire logic [12:0] gain_range_in,
  input wire logic div_wr_in,
  input wire logic [3:0] div_chan_in,
  input wire logic div_en_in,
  input wire logic avg_wr_in,
  input wire logic [3:0] avg_chan_in,
  input wire logic [8:0] avg_len_in,
  input wire logic sp_req_in,
  input wire logic scan_read_in,
  input wire logic adc_valid_in,
  input wire logic [17:0] adc_data_in,
  output logic conv_start_out,
  output logic [3:0] mux_chan_out,
  output logic [1:0] gain_out,
  output logic div_en_out,
  output logic scan_active_out,
  output logic cfg_reject_out,
  output logic smp_valid_out,
  output logic [3:0] smp_chan_out,
  output logic [15:0] smp_data_out,
  output logic [15:0] scans_avail_out
);

  logic [15:0][1:0] gain_reg;
  logic [15:0] div_reg;
  logic [15:0][3:0] win_reg;
  logic [15:0][15:0] result_reg;
  logic [14:0] tick_cnt_reg;
  aic_pkg::aic_scan_type st_reg;
  aic_pkg::aic_scan_type st_next;
  logic [3:0] ch_reg;
  logic sp_busy_reg;
  logic [3:0] sp_idx_reg;
  logic [1:0] snap_gain;
  logic [3:0] chan_last;
  logic gain_ok;
  logic div_ok;
  logic avg_ok;
  logic len_legal;
  logic [3:0] len_code;
  logic tick;
  logic take_smp;
  logic signed [17:0] adc_s;
  logic [15:0] clipped;
  logic avg_vld;
  logic [3:0] avg_chan;
  logic [15:0] avg_data;
  logic scan_done;
  logic sp_start;

  // Channel index limit follows the input numbering mode.
  assign chan_last = diff_mode_in ? aic_pkg::CHAN_LAST_DIFF : aic_pkg::CHAN_LAST_SE;
  assign gain_ok = gain_wr_in && gain_chan_in <= chan_last;
  assign div_ok = div_wr_in && div_chan_in <= chan_last;
  assign avg_ok = avg_wr_in && avg_chan_in <= chan_last && len_legal;

  // Only zero or a power of two from 2 to 256 is a legal window.
  assign len_legal = avg_len_in == 9'h000 || (avg_len_in[0] == 1'b0 && $onehot(avg_len_in));

  // Window length to its log2 code.
  always_comb begin
    len_code = 4'h0;
    for (int i = 1; i <= 8; i++) begin
      if (avg_len_in[i]) begin
        len_code = 4'(i);
      end
    end
  end

  aic_gain_snap u_snap (
    .range_in(gain_range_in),
    .gain_out(snap_gain)
  );

  // Per-channel configuration; gain and divider have separate write paths.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gain_reg <= {16{aic_pkg::GAIN_RST}};
      div_reg <= {16{aic_pkg::DIV_RST}};
      win_reg <= {16{aic_pkg::WIN_RST}};
      cfg_reject_out <= 1'b0;
    end else begin
      if (gain_ok) begin
        gain_reg[gain_chan_in] <= snap_gain;
      end
      if (div_ok) begin
        div_reg[div_chan_in] <= div_en_in;
      end
      if (avg_ok) begin
        win_reg[avg_chan_in] <= len_code;
      end
      cfg_reject_out <= avg_wr_in && !len_legal;
    end
  end

  // Conversion clock divider from the core clock.
  assign tick = tick_cnt_reg == 15'(TICK_CYCLES - 1);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt_reg <= 15'h0000;
    end else begin
      tick_cnt_reg <= tick ? 15'h0000 : tick_cnt_reg + 15'h0001;
    end
  end

  // Scan sequencer; a tick that lands while a scan runs is dropped.
  assign take_smp = st_reg == aic_pkg::ST_WAIT && adc_valid_in;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      aic_pkg::ST_IDLE: begin
        if (tick) begin
          st_next = aic_pkg::ST_START;
        end
      end
      aic_pkg::ST_START: begin
        st_next = aic_pkg::ST_WAIT;
      end
      aic_pkg::ST_WAIT: begin
        if (adc_valid_in) begin
          st_next = (ch_reg >= chan_last) ? aic_pkg::ST_IDLE : aic_pkg::ST_START;
        end
      end
      default: begin
        st_next = aic_pkg::ST_IDLE;
      end
    endcase
  end

  // Front-end controls are set up for the channel about to be converted.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= aic_pkg::ST_IDLE;
      ch_reg <= 4'h0;
      conv_start_out <= 1'b0;
      mux_chan_out <= 4'h0;
      gain_out <= aic_pkg::GAIN_RST;
      div_en_out <= aic_pkg::DIV_RST;
      scan_active_out <= 1'b0;
    end else begin
      st_reg <= st_next;
      conv_start_out <= st_next == aic_pkg::ST_START;
      scan_active_out <= st_next != aic_pkg::ST_IDLE;
      if (st_reg == aic_pkg::ST_IDLE) begin
        ch_reg <= 4'h0;
      end else if (take_smp) begin
        ch_reg <= ch_reg + 4'h1;
      end
      if (st_next == aic_pkg::ST_START) begin
        mux_chan_out <= (st_reg == aic_pkg::ST_IDLE) ? 4'h0 : ch_reg + 4'h1;
        gain_out <= gain_reg[(st_reg == aic_pkg::ST_IDLE) ? 4'h0 : ch_reg + 4'h1];
        div_en_out <= div_reg[(st_reg == aic_pkg::ST_IDLE) ? 4'h0 : ch_reg + 4'h1];
      end
    end
  end

  // Saturate the wider converter result to the sample width.
  assign adc_s = adc_data_in;
  assign clipped = (adc_s > aic_pkg::CLIP_HI) ? aic_pkg::SMP_HI :
    (adc_s < aic_pkg::CLIP_LO) ? aic_pkg::SMP_LO : adc_data_in[15:0];

  aic_avg u_avg (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(take_smp),
    .in_chan_in(ch_reg),
    .in_data_in(clipped),
    .in_win_in(win_reg[ch_reg]),
    .out_valid_out(avg_vld),
    .out_chan_out(avg_chan),
    .out_data_out(avg_data)
  );

  // Completed scan and single-point request decode.
  assign scan_done = avg_vld && avg_chan == chan_last && buffered_variable_count_mode_in;
  assign sp_start = sp_req_in && !buffered_variable_count_mode_in && !sp_busy_reg;

  // Latest result per channel, read by single-point requests.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result_reg <= '0;
    end else if (avg_vld) begin
      result_reg[avg_chan] <= avg_data;
    end
  end

  // Sample stream: every result in buffered mode, one sweep per request otherwise.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sp_busy_reg <= 1'b0;
      sp_idx_reg <= 4'h0;
      smp_valid_out <= 1'b0;
      smp_chan_out <= 4'h0;
      smp_data_out <= 16'h0000;
    end else begin
      if (sp_start) begin
        sp_busy_reg <= 1'b1;
        sp_idx_reg <= 4'h0;
      end else if (sp_busy_reg) begin
        sp_busy_reg <= sp_idx_reg < chan_last;
        sp_idx_reg <= sp_idx_reg + 4'h1;
      end
      if (buffered_variable_count_mode_in) begin
        smp_valid_out <= avg_vld;
        smp_chan_out <= avg_chan;
        smp_data_out <= avg_data;
      end else begin
        smp_valid_out <= sp_busy_reg;
        smp_chan_out <= sp_idx_reg;
        smp_data_out <= result_reg[sp_idx_reg];
      end
    end
  end

  // Available scan count; a new scan and a read in one cycle cancel.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scans_avail_out <= 16'h0000;
    end else if (!buffered_variable_count_mode_in) begin
      scans_avail_out <= 16'h0000;
    end else if (scan_done && !(scan_read_in && scans_avail_out != 16'h0000)) begin
      if (scans_avail_out != 16'hffff) begin
        scans_avail_out <= scans_avail_out + 16'h0001;
      end
    end else if (!scan_done && scan_read_in && scans_avail_out != 16'h0000) begin
      scans_avail_out <= scans_avail_out - 16'h0001;
    end
  end

  sequence s_sp_sweep8;
    smp_valid_out [*8] ##1 !smp_valid_out;
  endsequence

  a_chan_limit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    conv_start_out && diff_mode_in |-> mux_chan_out <= aic_pkg::CHAN_LAST_DIFF)
    else $error("Differential scan addressed a channel above seven.");

  a_gain_snap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    gain_ok |=> gain_reg[$past(gain_chan_in)] == $past(snap_gain))
    else $error("Gain write did not program the snapped gain.");

  a_gain_x1: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    gain_ok && (gain_range_in == aic_pkg::RNG_X1 || gain_range_in == aic_pkg::RNG_X1_DIV)
    |=> gain_reg[$past(gain_chan_in)] == aic_pkg::GAIN_X1)
    else $error("Ten or eighty volt range did not select unity gain.");

  a_div_keep: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !div_wr_in |=> $stable(div_reg))
    else $error("Divider enable changed without a divider write.");

  a_div_sep: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    div_ok |=> ((div_reg ^ $past(div_reg)) & ~(16'h0001 << $past(div_chan_in))) == 16'h0000)
    else $error("Divider write touched another channel.");

  a_win_legal: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    avg_wr_in && !len_legal |=> $stable(win_reg) && cfg_reject_out)
    else $error("Illegal window length was accepted.");

  a_tick_scan: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tick && st_reg == aic_pkg::ST_IDLE |=> conv_start_out && mux_chan_out == 4'h0)
    else $error("Conversion tick did not start a scan at channel zero.");

  a_clip_high: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    take_smp && win_reg[ch_reg] == 4'h0 && $signed(adc_data_in) > aic_pkg::CLIP_HI
    |=> avg_vld && avg_data == aic_pkg::SMP_HI)
    else $error("Over-range sample was not clipped to the top value.");

  a_clip_low: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    take_smp && win_reg[ch_reg] == 4'h0 && $signed(adc_data_in) < aic_pkg::CLIP_LO
    |=> avg_vld && avg_data == aic_pkg::SMP_LO)
    else $error("Under-range sample was not clipped to the bottom value.");

  a_sp_sweep: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sp_start && diff_mode_in && $stable(diff_mode_in) |=> ##1 s_sp_sweep8)
    else $error("Single-point request did not give one sample per channel.");

  a_scan_count: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    scan_done && !scan_read_in && scans_avail_out != 16'hffff
    |=> scans_avail_out == $past(scans_avail_out) + 16'h0001)
    else $error("Completed scan was not counted.");

endmodule

// ===== rtl/aic_pkg.sv
// Shared constants and types for the analog input conditioning block.
package aic_pkg;

  // Core clock and default conversion clock rate.
  localparam int CLK_HZ = 40000000;
  localparam int CONV_HZ = 2000;
  localparam int TICK_CYC = CLK_HZ / CONV_HZ;

  // Highest channel index for single-ended and differential numbering.
  localparam logic [3:0] CHAN_LAST_SE = 4'hf;
  localparam logic [3:0] CHAN_LAST_DIFF = 4'h7;

  // Gain codes driven to the gain stage.
  localparam logic [1:0] GAIN_X1 = 2'h0;
  localparam logic [1:0] GAIN_X4 = 2'h1;
  localparam logic [1:0] GAIN_X8 = 2'h2;
  localparam logic [1:0] GAIN_X64 = 2'h3;

  // Supported full-scale ranges in units of 1/64 V, undivided and divided.
  localparam logic [12:0] RNG_X64 = 13'h000a;
  localparam logic [12:0] RNG_X8 = 13'h0028;
  localparam logic [12:0] RNG_X64_DIV = 13'h0050;
  localparam logic [12:0] RNG_X4 = 13'h00a0;
  localparam logic [12:0] RNG_X8_DIV = 13'h0140;
  localparam logic [12:0] RNG_X1 = 13'h0280;
  localparam logic [12:0] RNG_X4_DIV = 13'h0500;
  localparam logic [12:0] RNG_X1_DIV = 13'h1400;

  // Attenuation of the input divider.
  localparam int DIV_FACTOR = 8;

  // Averaging window as log2 of its length; zero means off.
  localparam logic [3:0] WIN_LOG2_MAX = 4'h8;

  // Values after reset.
  localparam logic [1:0] GAIN_RST = GAIN_X1;
  localparam logic DIV_RST = 1'b0;
  localparam logic [3:0] WIN_RST = 4'h0;

  // Clip limits of a converted sample, held in the converter's 18-bit width.
  localparam logic signed [17:0] CLIP_HI = 18'sh07fff;
  localparam logic signed [17:0] CLIP_LO = 18'sh38000;
  localparam logic [15:0] SMP_HI = 16'h7fff;
  localparam logic [15:0] SMP_LO = 16'h8000;

  // Scan sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_WAIT = 3'b100
  } aic_scan_type;

endpackage

// ===== rtl/aic_gain_snap.sv
// Snaps a requested full-scale range to the nearest supported gain.
`timescale 1ns/10ps
module aic_gain_snap (
  input wire logic [12:0] range_in,
  output logic [1:0] gain_out
);

  // Sum of two neighbouring ranges, compared against twice the request.
  function automatic logic [13:0] mid2(input logic [12:0] a, input logic [12:0] b);
    mid2 = {1'b0, a} + {1'b0, b};
  endfunction

  logic [13:0] req2;

  assign req2 = {range_in, 1'b0};

  // Walk the sorted ranges; a tie goes to the smaller range.
  assign gain_out =
    (req2 <= mid2(aic_pkg::RNG_X64, aic_pkg::RNG_X8)) ? aic_pkg::GAIN_X64 :
    (req2 <= mid2(aic_pkg::RNG_X8, aic_pkg::RNG_X64_DIV)) ? aic_pkg::GAIN_X8 :
    (req2 <= mid2(aic_pkg::RNG_X64_DIV, aic_pkg::RNG_X4)) ? aic_pkg::GAIN_X64 :
    (req2 <= mid2(aic_pkg::RNG_X4, aic_pkg::RNG_X8_DIV)) ? aic_pkg::GAIN_X4 :
    (req2 <= mid2(aic_pkg::RNG_X8_DIV, aic_pkg::RNG_X1)) ? aic_pkg::GAIN_X8 :
    (req2 <= mid2(aic_pkg::RNG_X1, aic_pkg::RNG_X4_DIV)) ? aic_pkg::GAIN_X1 :
    (req2 <= mid2(aic_pkg::RNG_X4_DIV, aic_pkg::RNG_X1_DIV)) ? aic_pkg::GAIN_X4 :
    aic_pkg::GAIN_X1;

endmodule

// ===== rtl/aic_avg.sv
// Per-channel moving average over a power-of-two window of samples.
`timescale 1ns/10ps
module aic_avg (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  input wire logic [3:0] in_chan_in,
  input wire logic signed [15:0] in_data_in,
  input wire logic [3:0] in_win_in,
  output logic out_valid_out,
  output logic [3:0] out_chan_out,
  output logic [15:0] out_data_out
);

  logic signed [15:0] hist [0:4095];
  logic signed [24:0] sum_reg [0:15];
  logic [7:0] ptr_reg [0:15];
  logic [8:0] fill_reg [0:15];
  logic [3:0] lwin_reg [0:15];
  logic [8:0] win_len;
  logic signed [15:0] old_smp;
  logic restart;
  logic full;
  logic signed [24:0] sum_next;
  logic [8:0] fill_next;
  logic signed [24:0] mean;

  // Oldest sample of the window and the updated running sum.
  assign win_len = 9'h001 << in_win_in;
  assign old_smp = hist[{in_chan_in, ptr_reg[in_chan_in] - win_len[7:0]}];
  assign restart = lwin_reg[in_chan_in] != in_win_in;
  assign full = fill_reg[in_chan_in] >= win_len;
  assign sum_next = restart ? 25'(in_data_in) :
    sum_reg[in_chan_in] + 25'(in_data_in) - (full ? 25'(old_smp) : 25'sh0);
  assign fill_next = restart ? 9'h001 :
    (full ? fill_reg[in_chan_in] : fill_reg[in_chan_in] + 9'h001);
  assign mean = sum_next >>> in_win_in;

  // History store; it needs no reset because the fill count guards it.
  always_ff @(posedge clk_in) begin
    if (in_valid_in) begin
      hist[{in_chan_in, ptr_reg[in_chan_in]}] <= in_data_in;
    end
  end

  // Running state per channel; a window change restarts that channel.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 16; i++) begin
        sum_reg[i] <= 25'sh0;
        ptr_reg[i] <= 8'h00;
        fill_reg[i] <= 9'h000;
        lwin_reg[i] <= aic_pkg::WIN_RST;
      end
    end else if (in_valid_in) begin
      sum_reg[in_chan_in] <= sum_next;
      ptr_reg[in_chan_in] <= ptr_reg[in_chan_in] + 8'h01;
      fill_reg[in_chan_in] <= fill_next;
      lwin_reg[in_chan_in] <= in_win_in;
    end
  end

  // Result register; window zero passes the sample straight through.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_valid_out <= 1'b0;
      out_chan_out <= 4'h0;
      out_data_out <= 16'h0000;
    end else begin
      out_valid_out <= in_valid_in;
      out_chan_out <= in_chan_in;
      out_data_out <= (in_win_in == 4'h0) ? in_data_in : mean[15:0];
    end
  end

  a_avg_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_valid_in && in_win_in == 4'h0 |=> out_valid_out && out_data_out == $past(in_data_in))
    else $error("Window zero did not pass the sample through.");

endmodule

// ===== tb/aic_adc_model.sv
// Behavioural converter that answers every conversion start after a varying delay.
`timescale 1ns/10ps
module aic_adc_model (
  input wire logic clk_in,
  input wire logic conv_start_in,
  input wire logic [17:0] val_in,
  output logic adc_valid_out,
  output logic [17:0] adc_data_out
);
  int wait_cnt = -1;
  logic [17:0] last_data = 18'h00000;

  initial begin
    adc_valid_out = 1'b0;
    adc_data_out = 18'h3ffff;
  end

  // One result per start, two to four cycles after the start is sampled; the idle bus shows the inverted last result.
  always @(posedge clk_in) begin
    adc_valid_out <= 1'b0;
    adc_data_out <= ~last_data;
    if (conv_start_in) begin
      wait_cnt <= 1 + int'($urandom % 3);
    end else if (wait_cnt == 0) begin
      adc_valid_out <= 1'b1;
      adc_data_out <= val_in;
      last_data <= val_in;
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the analog input conditioning block.
`timescale 1ns/10ps
module tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic diff_mode_in = 1'b0;
  logic buffered_variable_count_mode_in = 1'b0;
  logic gain_wr_in = 1'b0, div_wr_in = 1'b0, div_en_in = 1'b0, avg_wr_in = 1'b0;
  logic sp_req_in = 1'b0, scan_read_in = 1'b0;
  logic [3:0] gain_chan_in = 4'h0, div_chan_in = 4'h0, avg_chan_in = 4'h0;
  logic [12:0] gain_range_in = 13'h0000;
  logic [8:0] avg_len_in = 9'h000;
  logic [17:0] val = 18'h00000, adc_data;
  logic adc_valid, conv_start_out, div_en_out, scan_active_out, cfg_reject_out, smp_valid_out;
  logic [3:0] mux_chan_out, smp_chan_out;
  logic [1:0] gain_out;
  logic [15:0] smp_data_out, scans_avail_out, v1, v2, cnt;
  int err_total = 0, samples_checked = 0, cyc_count = 0, i, m;
  logic [12:0] rngs [8] = '{13'h000a, 13'h0280, 13'h1400, 13'h0019,
                            13'h0000, 13'h1fff, 13'h0384, 13'h003c};
  logic [8:0] lens [15] = '{9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100,
                            9'h001, 9'h003, 9'h064, 9'h0ff, 9'h101, 9'h1ff, 9'h000};

  // Clock at 40 MHz.
  always #12.5 clk_in = ~clk_in;

  aic_top #(.TICK_CYCLES(120)) aic_top_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .diff_mode_in(diff_mode_in),
    .buffered_variable_count_mode_in(buffered_variable_count_mode_in),
    .gain_wr_in(gain_wr_in), .gain_chan_in(gain_chan_in), .gain_range_in(gain_range_in),
    .div_wr_in(div_wr_in), .div_chan_in(div_chan_in), .div_en_in(div_en_in),
    .avg_wr_in(avg_wr_in), .avg_chan_in(avg_chan_in), .avg_len_in(avg_len_in),
    .sp_req_in(sp_req_in), .scan_read_in(scan_read_in), .adc_valid_in(adc_valid),
    .adc_data_in(adc_data), .conv_start_out(conv_start_out), .mux_chan_out(mux_chan_out),
    .gain_out(gain_out), .div_en_out(div_en_out), .scan_active_out(scan_active_out),
    .cfg_reject_out(cfg_reject_out), .smp_valid_out(smp_valid_out),
    .smp_chan_out(smp_chan_out), .smp_data_out(smp_data_out),
    .scans_avail_out(scans_avail_out)
  );

  aic_adc_model aic_adc_model_i (
    .clk_in(clk_in), .conv_start_in(conv_start_out), .val_in(val),
    .adc_valid_out(adc_valid), .adc_data_out(adc_data)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Waits for a conversion start (smp low) or a delivered sample (smp high) of one channel.
  task automatic wait_ch(input bit smp, input logic [3:0] ch);
    int n;
    n = 0;
    cyc(1);
    while (n < 400 && !(smp ? (smp_valid_out === 1'b1 && smp_chan_out === ch)
                            : (conv_start_out === 1'b1 && mux_chan_out === ch))) begin
      cyc(1);
      n++;
    end
    if (n >= 400) begin
      err_total++;
      $display("[FAIL] %0t channel %0d never seen", $time, ch);
    end
  endtask

  // Configuration writes are one-cycle strobes with a settling cycle after them.
  task automatic wr_gain(input logic [3:0] ch, input logic [12:0] rng);
    gain_chan_in = ch;
    gain_range_in = rng;
    gain_wr_in = 1'b1;
    cyc(1);
    gain_wr_in = 1'b0;
    cyc(1);
  endtask

  task automatic wr_div(input logic [3:0] ch, input logic en);
    div_chan_in = ch;
    div_en_in = en;
    div_wr_in = 1'b1;
    cyc(1);
    div_wr_in = 1'b0;
    cyc(1);
  endtask

  task automatic wr_avg(input logic [3:0] ch, input logic [8:0] len, input logic rej);
    avg_chan_in = ch;
    avg_len_in = len;
    avg_wr_in = 1'b1;
    cyc(1);
    chk({15'h0000, cfg_reject_out}, {15'h0000, rej}, "length reject");
    avg_wr_in = 1'b0;
    cyc(1);
  endtask

  // Requests one single-point sweep and checks every delivered sample in order.
  task automatic sp_sweep(input int last, input logic [15:0] exp);
    sp_req_in = 1'b1;
    cyc(1);
    sp_req_in = 1'b0;
    cyc(1);
    for (int k = 0; k <= last; k++) begin
      chk({15'h0000, smp_valid_out}, 16'h0001, "sweep valid");
      chk({12'h000, smp_chan_out}, k[15:0], "sweep channel");
      chk(smp_data_out, exp, "sweep data");
      cyc(1);
    end
    chk({15'h0000, smp_valid_out}, 16'h0000, "sweep end");
  endtask

  // Nearest supported range over both divider columns; ties go to the smaller range.
  function automatic logic [1:0] snap(input logic [12:0] r);
    logic [12:0] rt [8] = '{aic_pkg::RNG_X64, aic_pkg::RNG_X8, aic_pkg::RNG_X64_DIV,
      aic_pkg::RNG_X4, aic_pkg::RNG_X8_DIV, aic_pkg::RNG_X1, aic_pkg::RNG_X4_DIV,
      aic_pkg::RNG_X1_DIV};
    logic [1:0] gt [8] = '{aic_pkg::GAIN_X64, aic_pkg::GAIN_X8, aic_pkg::GAIN_X64,
      aic_pkg::GAIN_X4, aic_pkg::GAIN_X8, aic_pkg::GAIN_X1, aic_pkg::GAIN_X4, aic_pkg::GAIN_X1};
    int best, d;
    logic [1:0] g;
    best = 1 << 20;
    g = aic_pkg::GAIN_X1;
    for (int k = 0; k < 8; k++) begin
      d = (r > rt[k]) ? int'(r - rt[k]) : int'(rt[k] - r);
      if (d < best) begin
        best = d;
        g = gt[k];
      end
    end
    return g;
  endfunction

  function automatic logic [15:0] clip(input logic [17:0] v);
    if ($signed(v) > aic_pkg::CLIP_HI) return aic_pkg::SMP_HI;
    if ($signed(v) < aic_pkg::CLIP_LO) return aic_pkg::SMP_LO;
    return v[15:0];
  endfunction

  // Cuts a hang short.
  always @(posedge clk_in) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 40000) begin
      err_total++;
      $display("[FAIL] %0t run too long", $time);
      give_verdict();
    end
  end

  // Main sequence of scenarios.
  initial begin
    void'($urandom(65));
    v1 = 16'($urandom);
    val = {{2{v1[15]}}, v1};
    cyc(20);
    chk({conv_start_out, smp_valid_out, gain_out, div_en_out, scans_avail_out[10:0]}, 16'h0000,
        "outputs in reset");
    rst_b_in = 1'b1;
    diff_mode_in = 1'b1;
    wr_div(4'ha, 1'b1);
    cyc(300);
    sp_sweep(7, clip(val));
    diff_mode_in = 1'b0;
    cyc(300);
    sp_sweep(15, clip(val));
    wait_ch(1'b0, 4'ha);
    chk({15'h0000, div_en_out}, 16'h0000, "refused divider write");
    for (i = 0; i < 12; i++) begin
      gain_range_in = (i < 8) ? rngs[i] : 13'($urandom);
      wr_gain(4'(i), gain_range_in);
      wait_ch(1'b0, 4'(i));
      chk({14'h0000, gain_out}, {14'h0000, snap(gain_range_in)}, "gain snap");
      chk({15'h0000, scan_active_out}, 16'h0001, "scan active");
    end
    wr_div(4'h5, 1'b1);
    wr_gain(4'h5, aic_pkg::RNG_X1_DIV);
    wr_gain(4'h6, aic_pkg::RNG_X4_DIV);
    wait_ch(1'b0, 4'h5);
    chk({13'h0000, gain_out, div_en_out}, {13'h0000, aic_pkg::GAIN_X1, 1'b1}, "divided x1");
    wait_ch(1'b0, 4'h6);
    chk({13'h0000, gain_out, div_en_out}, {13'h0000, aic_pkg::GAIN_X4, 1'b0}, "undivided");
    wr_div(4'h5, 1'b0);
    wait_ch(1'b0, 4'h5);
    chk({15'h0000, div_en_out}, 16'h0000, "divider off");
    buffered_variable_count_mode_in = 1'b1;
    val = 18'h1ffff;
    wait_ch(1'b1, 4'h0);
    wait_ch(1'b1, 4'h0);
    chk(smp_data_out, aic_pkg::SMP_HI, "clip high");
    val = 18'h20000;
    wait_ch(1'b1, 4'h0);
    wait_ch(1'b1, 4'h0);
    chk(smp_data_out, aic_pkg::SMP_LO, "clip low");
    for (i = 0; i < 15; i++) begin
      wr_avg(4'h0, lens[i], i >= 8 && i < 14);
    end
    val = {{2{v1[15]}}, v1};
    wr_avg(4'h0, 9'h004, 1'b0);
    repeat (5) wait_ch(1'b1, 4'h0);
    chk(smp_data_out, v1, "steady mean");
    v2 = 16'($urandom);
    val = {{2{v2[15]}}, v2};
    wait_ch(1'b1, 4'h0);
    m = (3 * int'($signed(v1)) + int'($signed(v2))) >>> 2;
    chk(smp_data_out, m[15:0], "mean of last four");
    wait_ch(1'b1, 4'h1);
    chk(smp_data_out, v2, "other channel unaveraged");
    cnt = scans_avail_out;
    wait_ch(1'b1, 4'hf);
    cyc(2);
    chk(scans_avail_out, cnt + 16'h0001, "scan counted");
    chk({15'h0000, scan_active_out}, 16'h0000, "scan idle");
    cnt = scans_avail_out;
    scan_read_in = 1'b1;
    cyc(1);
    scan_read_in = 1'b0;
    cyc(1);
    chk(scans_avail_out, cnt - 16'h0001, "scan read");
    buffered_variable_count_mode_in = 1'b0;
    cyc(2);
    chk(scans_avail_out, 16'h0000, "scans cleared");
    // A second reset in mid-run must bring every window back to zero.
    rst_b_in = 1'b0;
    cyc(2);
    chk({conv_start_out, scan_active_out, smp_valid_out, cfg_reject_out, scans_avail_out[11:0]},
        16'h0000, "outputs in second reset");
    rst_b_in = 1'b1;
    buffered_variable_count_mode_in = 1'b1;
    wait_ch(1'b1, 4'h0);
    chk(smp_data_out, v2, "window zero after reset");
    give_verdict();
  end
endmodule
